/* rtl/timeout_report_count.sv */
`timescale 1ns/100ps
// Time-out discard, status, reporting and counting for one switch port
module timeout_report_count (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [timeout_report_pkg::num_class-1:0] head_valid,
	input wire logic [timeout_report_pkg::num_class-1:0] head_taken,
	output logic [timeout_report_pkg::num_class-1:0] discard,
	output logic msg_valid,
	output logic [1:0] msg_severity,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import timeout_report_pkg::*;

	typedef struct packed {
		// Configuration; sticky, loaded with its reset values only by resetn
		logic [5:0] severity;
		logic enable;
		logic [15:0] limit;
		// Event status and the reports still owed to the root
		logic [2:0] status;
		logic [2:0] irq_enable;
		logic [2:0] pend;
		logic [1:0] msg_sev;
		logic msg_valid;
		logic irq;
		// Write channel holding registers and response
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		// Read channel response
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// Ready outputs, registered so no port is combinational
		logic awready;
		logic wready;
		logic arready;
	} port_state_type;
	port_state_type state_reg;
	port_state_type state_next;

	// Per-class timer strobes and the three counter values
	logic [2:0] expire;
	logic [7:0] cnt_posted;
	logic [7:0] cnt_nonposted;
	logic [8:0] cnt_completion;
	logic count_read;

	// One age timer per class; expiry drops the head TLP
	// Enable and limit are shared; each class ages on its own
	genvar gi;
	generate
		for (gi = 0; gi < num_class; gi++) begin : g_timer
			class_timer u_timer (
				.mclk(mclk),
				.resetn(resetn),
				.head_valid(head_valid[gi]),
				.head_taken(head_taken[gi]),
				.enable(state_reg.enable),
				.limit(state_reg.limit),
				.expire(expire[gi])
			);
		end
	endgenerate

	// Read of the count register clears all three fields at once.
	// Clearing on the edge that latches the read data means
	// nothing counted between capture and clear is lost.
	assign count_read = s_axi_arvalid && !state_reg.rvalid &&
		s_axi_araddr[11:2] == count_offset[11:2];

	// Completion field is one bit wider than the other two
	sat_counter #(.width(8)) u_cnt_posted (
		.mclk(mclk),
		.resetn(resetn),
		.incr(expire[0]),
		.clear(count_read),
		.value(cnt_posted)
	);
	sat_counter #(.width(8)) u_cnt_nonposted (
		.mclk(mclk),
		.resetn(resetn),
		.incr(expire[1]),
		.clear(count_read),
		.value(cnt_nonposted)
	);
	sat_counter #(.width(9)) u_cnt_completion (
		.mclk(mclk),
		.resetn(resetn),
		.incr(expire[2]),
		.clear(count_read),
		.value(cnt_completion)
	);

	always_comb begin
		logic [2:0] rise;
		logic [2:0] clr;
		logic [1:0] sev;
		logic do_write;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;

		// Working values; none of them outlives the cycle
		rise = '0;
		clr = '0;
		sev = sev_none;
		do_write = 1'b0;
		waddr = '0;
		wdata = '0;
		wstrb = '0;
		state_next = state_reg;

		// Write channel capture; address and data in either order
		// A held half waits for its partner; the response blocks both
		if (s_axi_awvalid && !state_reg.aw_held && !state_reg.bvalid) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_held && !state_reg.bvalid) begin
			state_next.w_held = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		// Both halves in hand: perform the write, raise the response
		if (state_reg.aw_held && state_reg.w_held) begin
			do_write = 1'b1;
			waddr = state_reg.aw_addr;
			wdata = state_reg.w_data;
			wstrb = state_reg.w_strb;
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = resp_okay;
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end

		// Register writes; each byte lane is gated by its own strobe
		if (do_write) begin
			case (waddr[11:2])
				control_offset[11:2]: begin
					if (wstrb[0]) begin
						state_next.severity = wdata[5:0];
					end
				end
				enable_offset[11:2]: begin
					if (wstrb[0]) begin
						state_next.enable = wdata[0];
					end
				end
				irq_enable_offset[11:2]: begin
					if (wstrb[0]) begin
						state_next.irq_enable = wdata[2:0];
					end
				end
				irq_clear_offset[11:2]: begin
					if (wstrb[0]) begin
						clr = wdata[2:0];
					end
				end
				limit_offset[11:2]: begin
					// Each byte of the limit has its own strobe
					if (wstrb[0]) begin
						state_next.limit[7:0] = wdata[7:0];
					end
					if (wstrb[1]) begin
						state_next.limit[15:8] = wdata[15:8];
					end
				end
				// Read-only registers accept the write and ignore it
				count_offset[11:2], status_offset[11:2]: begin
				end
				default: begin
					state_next.bresp = resp_slverr;
				end
			endcase
		end

		// Status: a discard wins over a clear in the same cycle
		// The edge test uses the old status, so a held bit stays silent
		rise = expire & ~state_reg.status;
		state_next.status = (state_reg.status & ~clr) | expire;

		// Pending reports; one message per cycle, posted first
		state_next.pend = state_reg.pend | rise;
		state_next.msg_valid = 1'b0;
		// Severity none retires the report without a message
		for (int i = 0; i < num_class; i++) begin
			if (state_reg.pend[i] && !state_next.msg_valid) begin
				sev = state_reg.severity[2*i +: 2];
				state_next.pend[i] = rise[i];
				if (sev != sev_none) begin
					state_next.msg_valid = 1'b1;
					state_next.msg_sev = sev;
				end
			end
		end

		// Interrupt follows the updated status, so a clear drops it at once
		state_next.irq = |(state_next.status & state_reg.irq_enable);

		// Read channel; answer one cycle after the address is taken
		// Unused and reserved bits read as zero
		if (s_axi_arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = resp_okay;
			state_next.rdata = '0;
			case (s_axi_araddr[11:2])
				control_offset[11:2]: begin
					state_next.rdata[5:0] = state_reg.severity;
				end
				count_offset[11:2]: begin
					// Bits 31:25 stay zero from the fill above
					state_next.rdata[7:0] = cnt_posted;
					state_next.rdata[15:8] = cnt_nonposted;
					state_next.rdata[24:16] = cnt_completion;
				end
				enable_offset[11:2]: begin
					state_next.rdata[0] = state_reg.enable;
				end
				status_offset[11:2]: begin
					state_next.rdata[2:0] = state_reg.status;
				end
				irq_enable_offset[11:2]: begin
					state_next.rdata[2:0] = state_reg.irq_enable;
				end
				irq_clear_offset[11:2]: begin
				end
				limit_offset[11:2]: begin
					state_next.rdata[15:0] = state_reg.limit;
				end
				default: begin
					state_next.rresp = resp_slverr;
				end
			endcase
		end else if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end

		// Ready flops mirror the holding flags of the next cycle
		state_next.awready = !state_next.aw_held && !state_next.bvalid;
		state_next.wready = !state_next.w_held && !state_next.bvalid;
		state_next.arready = !state_next.rvalid;
	end

	// Sticky fields reset only on resetn, the fundamental reset
	// Ready flops reset high so a request may start at the first edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.severity <= control_reset;
			state_reg.enable <= enable_reset;
			state_reg.limit <= limit_reset;
			state_reg.awready <= 1'b1;
			state_reg.wready <= 1'b1;
			state_reg.arready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Discard strobes come straight from the timer flops
	assign discard = expire;
	assign msg_valid = state_reg.msg_valid;
	assign msg_severity = state_reg.msg_sev;
	assign irq = state_reg.irq;

	// Write channel outputs
	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;

	// Read channel outputs
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
endmodule

/* rtl/timeout_report_pkg.sv */
// Notes on behaviour
// - posted severity bits 1:0, reset nonfatal
// - non-posted severity bits 3:2, reset none
// - completion severity bits 5:4, upper bits zero
// - report only on status rising edge
// - severity codes none, cor, nonfatal, fatal
// - posted discard counter bits 7:0
// - non-posted discard counter bits 15:8
// - counters saturate, sticky, reset zero
// - reading counters clears them
// - enable bit drops TLPs waiting too long
package timeout_report_pkg;
	localparam int addr_width = 12;
	localparam logic [11:0] control_offset = 12'h4E8;
	localparam logic [11:0] count_offset = 12'h4EC;
	localparam logic [11:0] enable_offset = 12'h4E4;
	localparam logic [11:0] status_offset = 12'h4F0;
	localparam logic [11:0] irq_enable_offset = 12'h4F4;
	localparam logic [11:0] irq_clear_offset = 12'h4F8;
	localparam logic [11:0] limit_offset = 12'h4FC;
	localparam int posted_sev_lsb = 0;
	localparam int nonposted_sev_lsb = 2;
	localparam int completion_sev_lsb = 4;
	localparam int posted_cnt_lsb = 0;
	localparam int nonposted_cnt_lsb = 8;
	localparam int completion_cnt_lsb = 16;
	localparam logic [5:0] control_reset = 6'h02;
	localparam logic enable_reset = 1'h1;
	localparam logic [15:0] limit_reset = 16'h0FA0;
	localparam int num_class = 3;
	localparam logic [1:0] sev_none = 2'h0;
	localparam logic [1:0] sev_cor = 2'h1;
	localparam logic [1:0] sev_nonfatal = 2'h2;
	localparam logic [1:0] sev_fatal = 2'h3;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

/* rtl/class_timer.sv */
`timescale 1ns/100ps
// Age timer for the head TLP of one ingress queue class
module class_timer
	import timeout_report_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic head_valid,
	input wire logic head_taken,
	input wire logic enable,
	input wire logic [15:0] limit,
	output logic expire
);
	typedef struct packed {
		logic [15:0] age;
		logic expire;
	} timer_state_type;
	timer_state_type state_reg;
	timer_state_type state_next;

	// Age restarts whenever the head leaves; expiry drops the head
	always_comb begin
		state_next = state_reg;
		state_next.expire = 1'b0;
		if (!head_valid || head_taken || state_reg.expire) begin
			state_next.age = 16'h0000;
		end else if (enable && state_reg.age >= limit) begin
			state_next.expire = 1'b1;
		end else if (enable) begin
			state_next.age = state_reg.age + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign expire = state_reg.expire;
endmodule

/* rtl/sat_counter.sv */
`timescale 1ns/100ps
// Saturating clear-on-read counter; a read clears only what was returned
module sat_counter #(
	parameter int width = 8
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic incr,
	input wire logic clear,
	output logic [width-1:0] value
);
	typedef struct packed {
		logic [width-1:0] count;
	} counter_state_type;
	counter_state_type state_reg;
	counter_state_type state_next;

	// Event in the clearing cycle is kept as a count of one
	always_comb begin
		state_next = state_reg;
		if (clear) begin
			state_next.count = incr ? width'(1) : '0;
		end else if (incr && state_reg.count != '1) begin
			state_next.count = state_reg.count + width'(1);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign value = state_reg.count;
endmodule

/* tb/err_sink.sv */
`timescale 1ns/100ps
// Root side of the link: keeps each error message for one cycle
module err_sink (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic msg_valid,
	input wire logic [1:0] msg_severity,
	output logic got,
	output logic [1:0] sev
);
	// Registered, so the bench samples a settled copy
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			got <= 1'b0;
			sev <= 2'h0;
		end else begin
			got <= msg_valid;
			sev <= msg_severity;
		end
	end
endmodule

/* tb/timeout_report_count_chk.sv */
`timescale 1ns/100ps
// Port-level checks on drops, reports and the register bus
module timeout_report_count_chk
	import timeout_report_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [num_class-1:0] head_valid,
	input wire logic [num_class-1:0] discard,
	input wire logic msg_valid,
	input wire logic [1:0] msg_severity,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	logic [11:0] ar_reg;
	logic any_drop;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	assign any_drop = |discard;
	// Address of the read in flight; the bus releases it after the handshake
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ar_reg <= 12'h000;
		else if (s_axi_arvalid && s_axi_arready)
			ar_reg <= s_axi_araddr;
	end
	a_msg_has_sev: assert property (msg_valid |-> msg_severity != sev_none)
		else $error("message sent with no severity");
	a_msg_after_drop: assert property (msg_valid |->
		$past(any_drop) || $past(any_drop, 2) || $past(any_drop, 3) ||
		$past(any_drop, 4))
		else $error("message without a recent drop");
	a_drop_needs_head: assert property ((discard & ~$past(head_valid)) == '0)
		else $error("drop of an empty queue head");
	a_b_after_both: assert property ($rose(s_axi_bvalid) |->
		!s_axi_awready && !s_axi_wready)
		else $error("write answered before address and data");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
	a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer withdrawn or changed");
	a_ctl_top_zero: assert property (s_axi_rvalid && ar_reg == control_offset
		|-> s_axi_rdata[31:6] == '0)
		else $error("control upper bits not zero");
	a_cnt_top_zero: assert property (s_axi_rvalid && ar_reg == count_offset
		|-> s_axi_rdata[31:25] == '0)
		else $error("count upper bits not zero");
	c_fatal: cover property (msg_valid && msg_severity == sev_fatal);
	c_all_drop: cover property (&discard);
	c_cnt_read: cover property (s_axi_rvalid && ar_reg == count_offset);
endmodule
bind timeout_report_count timeout_report_count_chk chk (.mclk, .resetn,
	.head_valid, .discard, .msg_valid, .msg_severity, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready);

/* tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	import timeout_report_pkg::*;
	logic mclk = 0, resetn = 0, cnt_on = 0, hs, aw_ok, w_ok;
	logic [2:0] head_valid = 0, head_taken = 0, discard;
	logic msg_valid, irq, got, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] msg_severity, sev, s, s_axi_bresp, s_axi_rresp;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] mq[$], bq[$], e_m, e_b;
	logic [33:0] rq[$], e_r;
	int failures = 0, tests_run = 0, seed = 32'h5274, c, n[3] = '{0, 0, 0};
	wire [5:0] rdy = {discard, s_axi_bvalid, s_axi_rvalid, s_axi_arready};

	timeout_report_count DUT (.*);
	err_sink root (.*);

	// 40 MHz
	initial forever #12.5 mclk = ~mclk;

	// Compares each answer with the oldest note; sampled mid-cycle to stay clear
	// of the edge that updates the flops
	always @(negedge mclk) begin
		if (got) begin
			e_m = mq.pop_front();
			`CHK(sev, e_m)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			e_b = bq.pop_front();
			`CHK(s_axi_bresp, e_b)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e_r = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, e_r)
		end
		if (cnt_on)
			for (int k = 0; k < 3; k++)
				n[k] += discard[k];
	end

	task automatic end_of_test();
		if (failures == 0 && tests_run > 0 && mq.size() == 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Waits for one of the rdy bits at a rising edge, with a bound
	task automatic wt(input int k);
		int i;
		for (i = 0; i < 60; i++) begin
			@(negedge mclk);
			hs = rdy[k];
			@(posedge mclk);
			if (hs) break;
		end
		if (i >= 60) begin
			failures++;
			end_of_test();
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] v,
		input logic [1:0] r = resp_okay);
		int i;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		// Address and data are released each on its own ready
		for (i = 0; i < 60; i++) begin
			@(negedge mclk);
			if (!s_axi_awvalid && !s_axi_wvalid) break;
			aw_ok = s_axi_awready;
			w_ok = s_axi_wready;
			@(posedge mclk);
			if (aw_ok) s_axi_awvalid <= 0;
			if (w_ok) s_axi_wvalid <= 0;
		end
		if (i >= 60) begin
			failures++;
			end_of_test();
		end
		wt(2);
	endtask

	task automatic axr(input logic [11:0] a, input logic [31:0] v,
		input logic [1:0] r = resp_okay);
		rq.push_back({r, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		wt(0);
		s_axi_arvalid <= 0;
		wt(1);
	endtask

	// Holds one queue head until it is dropped
	task automatic tmo(input int k);
		head_valid[k] <= 1;
		wt(3 + k);
		head_valid[k] <= 0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic irqck(input logic e);
		@(negedge mclk);
		`CHK(irq, e)
		@(posedge mclk);
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1;
		axr(control_offset, 32'h2);
		axr(enable_offset, 32'h1);
		axr(count_offset, 32'h0);
		axr(12'h100, 32'h0, resp_slverr);
		axw(12'h100, 32'hFFFFFFFF, resp_slverr);
		axw(limit_offset, 32'h4);
		axw(irq_enable_offset, 32'h7);
		// Every severity once; second drop while status is held stays silent
		for (int k = 0; k < 4; k++) begin
			c = k % 3;
			s = k[1:0];
			d = $random(seed);
			d[5:0] = 6'(s) << (2 * c);
			axw(control_offset, d);
			axr(control_offset, {26'h0, d[5:0]});
			if (s != sev_none) mq.push_back(s);
			tmo(c);
			tmo(c);
			axr(status_offset, 32'h1 << c);
			irqck(1);
			axr(count_offset, 32'h2 << (8 * c));
			axr(count_offset, 32'h0);
			axw(irq_clear_offset, 32'h1 << c);
			irqck(0);
			axr(status_offset, 32'h0);
		end
		// Long run with reporting off, so every counter saturates
		axw(control_offset, 32'h0);
		axw(limit_offset, 32'h1);
		cnt_on <= 1;
		head_valid <= 3'h7;
		repeat (4000) @(posedge mclk);
		head_valid <= 3'h0;
		repeat (3) @(posedge mclk);
		cnt_on <= 0;
		axr(count_offset, {7'h0, 9'(n[2] > 511 ? 511 : n[2]),
			8'(n[1] > 255 ? 255 : n[1]), 8'(n[0] > 255 ? 255 : n[0])});
		axw(irq_clear_offset, 32'h7);
		axw(limit_offset, 32'h8);
		// No drops while disabled, nor for heads forwarded in time
		n = '{0, 0, 0};
		axw(enable_offset, 32'h0);
		cnt_on <= 1;
		head_valid <= 3'h7;
		repeat (40) @(posedge mclk);
		axw(enable_offset, 32'h1);
		for (int k = 0; k < 40; k++) begin
			head_taken <= {3{k % 3 == 0}};
			@(posedge mclk);
		end
		head_valid <= 3'h0;
		head_taken <= 3'h0;
		repeat (3) @(posedge mclk);
		`CHK(n[0] + n[1] + n[2], 0)
		axr(count_offset, 32'h0);
		end_of_test();
	end
endmodule
